// ==== design/ubr_pkg.sv ====
// package: register map, reset values, pin modes and carrier structs for the bridge register bank
package ubr_pkg;
	localparam logic [3:0] ADDR_BAUD_LOW = 4'h0;
	localparam logic [3:0] ADDR_BAUD_HIGH = 4'h1;
	localparam logic [3:0] ADDR_MODE_LOW = 4'h2;
	localparam logic [3:0] ADDR_MODE_HIGH = 4'h3;
	localparam logic [3:0] ADDR_PIN_LEVEL = 4'h4;
	localparam logic [3:0] ADDR_RESERVED = 4'h5;
	localparam logic [3:0] ADDR_OWN_ADDR = 4'h6;
	localparam logic [3:0] ADDR_SCL_LOW = 4'h7;
	localparam logic [3:0] ADDR_SCL_HIGH = 4'h8;
	localparam logic [3:0] ADDR_TIMEOUT = 4'h9;
	localparam logic [3:0] ADDR_RESULT = 4'hA;

	localparam logic [7:0] RST_BAUD_LOW = 8'hF0;
	localparam logic [7:0] RST_BAUD_HIGH = 8'h02;
	localparam logic [7:0] RST_MODE = 8'h55;
	localparam logic [7:0] RST_PIN_LATCH = 8'hFF;
	localparam logic [7:0] RST_OWN_ADDR = 8'h26;
	localparam logic [7:0] RST_SCL_LOW = 8'h13;
	localparam logic [7:0] RST_SCL_HIGH = 8'h13;
	localparam logic [7:0] RST_TIMEOUT = 8'h66;
	localparam logic [7:0] RST_RESULT = 8'hF0;

	localparam logic [3:0] RESULT_UPPER = 4'hF;
	localparam logic [3:0] RESULT_OK = 4'h0;
	localparam logic [3:0] RESULT_ADDRESS_NOT_ACKED = 4'h1;
	localparam logic [3:0] RESULT_DATA_NOT_ACKED = 4'h2;
	localparam logic [3:0] RESULT_TIMED_OUT = 4'h8;

	localparam int TIMEOUT_ENABLE_BIT = 0;
	localparam int BAUD_OFFSET = 16;
	localparam logic [8:0] SCL_MIN_SUM = 9'h00A;
	// clock 7.3728 MHz; one time-out unit is 256/57600 s = 32768 cycles
	localparam int TIMEOUT_UNIT_CYCLES = 32768;
	localparam int GLITCH_CYCLES = 3;

	typedef enum logic [1:0] {
		UBR_MODE_QUASI = 2'h0,
		UBR_MODE_INPUT = 2'h1,
		UBR_MODE_PUSH = 2'h2,
		UBR_MODE_OPEN = 2'h3
	} ubr_mode_t;

	// register access from the command parser
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ubr_req_t;

	// per-pin drive: strong enable, strong level, weak pull-up
	typedef struct packed {
		logic [7:0] oe;
		logic [7:0] o;
		logic [7:0] weak_up;
	} ubr_pins_t;

	// end-of-frame outcome reported by the bus sequencer
	typedef struct packed {
		logic done;
		logic [3:0] code;
	} ubr_frame_t;

	// bus timing handed to the sequencer
	typedef struct packed {
		logic [7:0] scl_high;
		logic [7:0] scl_low;
		logic scl_sum_ok;
		logic timeout_en;
		logic [6:0] timeout_val;
	} ubr_bus_cfg_t;
endpackage

// ==== design/ubr_register_bank.sv ====
// module: register bank of the uart-to-bus bridge, pin drivers and scl-low time-out
`timescale 1ns/10ps

module ubr_register_bank #(
	parameter int PINS = 8,
	parameter int TIMEOUT_UNIT = ubr_pkg::TIMEOUT_UNIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire ubr_pkg::ubr_req_t req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic [15:0] baud_divisor_o,
	output logic [16:0] baud_period_o,
	input wire ubr_pkg::ubr_frame_t frame_i,
	input wire logic bus_transition_i,
	input wire logic scl_low_i,
	output ubr_pkg::ubr_bus_cfg_t bus_cfg_o,
	output logic bus_reset_o,
	output logic [7:0] own_address_o,
	input wire logic [PINS-1:0] pin_i,
	output ubr_pkg::ubr_pins_t pins_o
);
	localparam int GW = $clog2(ubr_pkg::GLITCH_CYCLES + 1);
	localparam int UW = $clog2(TIMEOUT_UNIT + 1);

	typedef struct packed {
		logic [7:0] baud_low;
		logic [7:0] baud_high;
		logic [15:0] baud_active;
		logic [7:0] mode_low;
		logic [7:0] mode_high;
		logic [7:0] latch;
		logic [7:0] own_addr;
		logic [7:0] scl_low;
		logic [7:0] scl_high;
		logic [7:0] timeout;
		logic [3:0] result;
		logic [7:0] rdata;
		logic rvalid;
		logic [PINS-1:0] sync1;
		logic [PINS-1:0] sync2;
		logic [PINS-1:0] filt;
		logic [PINS-1:0][GW-1:0] gcnt;
		logic [UW-1:0] unit_cnt;
		logic [6:0] units;
		logic bus_reset;
	} ubr_state_t;

	ubr_state_t state_reg;
	ubr_state_t state_next;

	// mode of one pin out of the two mode registers
	function automatic ubr_pkg::ubr_mode_t pin_mode(input logic [15:0] modes, input int idx);
		pin_mode = ubr_pkg::ubr_mode_t'(modes[2*idx +: 2]);
	endfunction

	// register read mux; reused for the read answer
	function automatic logic [7:0] reg_read(input ubr_state_t s, input logic [7:0] addr);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
			{4'h0, ubr_pkg::ADDR_BAUD_LOW}: v = s.baud_low;
			{4'h0, ubr_pkg::ADDR_BAUD_HIGH}: v = s.baud_high;
			{4'h0, ubr_pkg::ADDR_MODE_LOW}: v = s.mode_low;
			{4'h0, ubr_pkg::ADDR_MODE_HIGH}: v = s.mode_high;
			{4'h0, ubr_pkg::ADDR_PIN_LEVEL}: v = s.filt;
			{4'h0, ubr_pkg::ADDR_OWN_ADDR}: v = s.own_addr;
			{4'h0, ubr_pkg::ADDR_SCL_LOW}: v = s.scl_low;
			{4'h0, ubr_pkg::ADDR_SCL_HIGH}: v = s.scl_high;
			{4'h0, ubr_pkg::ADDR_TIMEOUT}: v = s.timeout;
			{4'h0, ubr_pkg::ADDR_RESULT}: v = {ubr_pkg::RESULT_UPPER, s.result};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	logic [15:0] modes;
	assign modes = {state_reg.mode_high, state_reg.mode_low};

	always_comb begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;

		// pin inputs: two-stage sync, then a level must hold before it is accepted
		state_next.sync1 = pin_i;
		state_next.sync2 = state_reg.sync1;
		for (int i = 0; i < PINS; i++) begin
			if (state_reg.sync2[i] == state_reg.filt[i]) begin
				state_next.gcnt[i] = '0;
			end else if (state_reg.gcnt[i] == GW'(ubr_pkg::GLITCH_CYCLES - 1)) begin
				state_next.filt[i] = state_reg.sync2[i];
				state_next.gcnt[i] = '0;
			end else begin
				state_next.gcnt[i] = state_reg.gcnt[i] + GW'(1);
			end
		end

		// host writes take effect on the next enabled clock edge after the address is decoded
		if (req_i.wr) begin
			unique case (req_i.addr)
				{4'h0, ubr_pkg::ADDR_BAUD_LOW}: state_next.baud_low = req_i.wdata;
				{4'h0, ubr_pkg::ADDR_BAUD_HIGH}: begin
					state_next.baud_high = req_i.wdata;
					// low byte alone never changes the rate, avoiding a torn divisor
					state_next.baud_active = {req_i.wdata, state_reg.baud_low};
				end
				{4'h0, ubr_pkg::ADDR_MODE_LOW}: state_next.mode_low = req_i.wdata;
				{4'h0, ubr_pkg::ADDR_MODE_HIGH}: state_next.mode_high = req_i.wdata;
				{4'h0, ubr_pkg::ADDR_PIN_LEVEL}: state_next.latch = req_i.wdata;
				{4'h0, ubr_pkg::ADDR_OWN_ADDR}: state_next.own_addr = req_i.wdata;
				{4'h0, ubr_pkg::ADDR_SCL_LOW}: state_next.scl_low = req_i.wdata;
				{4'h0, ubr_pkg::ADDR_SCL_HIGH}: state_next.scl_high = req_i.wdata;
				{4'h0, ubr_pkg::ADDR_TIMEOUT}: state_next.timeout = req_i.wdata;
				default: ;
			endcase
		end
		if (req_i.rd) begin
			state_next.rdata = reg_read(state_reg, req_i.addr);
			state_next.rvalid = 1'b1;
		end

		// frame outcome only from the sequencer, never from the host
		if (frame_i.done) begin
			state_next.result = frame_i.code;
		end

		// scl-low watchdog: units of 256/57600 s, reloaded on every bus transition
		state_next.bus_reset = 1'b0;
		if (!state_reg.timeout[ubr_pkg::TIMEOUT_ENABLE_BIT] || bus_transition_i || !scl_low_i) begin
			state_next.unit_cnt = '0;
			state_next.units = '0;
		end else if (state_reg.unit_cnt == UW'(TIMEOUT_UNIT - 1)) begin
			state_next.unit_cnt = '0;
			if (state_reg.units + 7'h01 >= state_reg.timeout[7:1]) begin
				state_next.bus_reset = 1'b1;
				state_next.units = '0;
			end else begin
				state_next.units = state_reg.units + 7'h01;
			end
		end else begin
			state_next.unit_cnt = state_reg.unit_cnt + UW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= '0;
			state_reg.baud_low <= ubr_pkg::RST_BAUD_LOW;
			state_reg.baud_high <= ubr_pkg::RST_BAUD_HIGH;
			state_reg.baud_active <= {ubr_pkg::RST_BAUD_HIGH, ubr_pkg::RST_BAUD_LOW};
			state_reg.mode_low <= ubr_pkg::RST_MODE;
			state_reg.mode_high <= ubr_pkg::RST_MODE;
			state_reg.latch <= ubr_pkg::RST_PIN_LATCH;
			state_reg.own_addr <= ubr_pkg::RST_OWN_ADDR;
			state_reg.scl_low <= ubr_pkg::RST_SCL_LOW;
			state_reg.scl_high <= ubr_pkg::RST_SCL_HIGH;
			state_reg.timeout <= ubr_pkg::RST_TIMEOUT;
			state_reg.result <= ubr_pkg::RST_RESULT[3:0];
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	// pin drivers per mode
	for (genvar p = 0; p < PINS; p++) begin : g_pin
		always_comb begin
			pins_o.oe[p] = 1'b0;
			pins_o.o[p] = 1'b0;
			pins_o.weak_up[p] = 1'b0;
			unique case (pin_mode(modes, p))
				ubr_pkg::UBR_MODE_QUASI: begin
					pins_o.oe[p] = !state_reg.latch[p];
					pins_o.weak_up[p] = state_reg.latch[p];
				end
				ubr_pkg::UBR_MODE_INPUT: pins_o.oe[p] = 1'b0;
				ubr_pkg::UBR_MODE_PUSH: begin
					pins_o.oe[p] = 1'b1;
					pins_o.o[p] = state_reg.latch[p];
				end
				ubr_pkg::UBR_MODE_OPEN: pins_o.oe[p] = !state_reg.latch[p];
			endcase
		end
	end

	assign rdata_o = state_reg.rdata;
	assign rvalid_o = state_reg.rvalid;
	assign baud_divisor_o = state_reg.baud_active;
	// bit period in clocks is offset plus divisor
	assign baud_period_o = 17'(ubr_pkg::BAUD_OFFSET) + {1'b0, state_reg.baud_active};
	assign bus_cfg_o.scl_high = state_reg.scl_high;
	assign bus_cfg_o.scl_low = state_reg.scl_low;
	assign bus_cfg_o.scl_sum_ok =
		({1'b0, state_reg.scl_high} + {1'b0, state_reg.scl_low}) >= ubr_pkg::SCL_MIN_SUM;
	assign bus_cfg_o.timeout_en = state_reg.timeout[ubr_pkg::TIMEOUT_ENABLE_BIT];
	assign bus_cfg_o.timeout_val = state_reg.timeout[7:1];
	assign bus_reset_o = state_reg.bus_reset;
	assign own_address_o = state_reg.own_addr;
endmodule // ubr_register_bank

// ==== tb/ubr_pin_env.sv ====
// pin environment: pull-ups and an outside part that may pull pins low
`timescale 1ns/10ps
module ubr_pin_env (
	input wire ubr_pkg::ubr_pins_t pins_i,
	input wire logic [7:0] ext_low_i,
	output logic [7:0] level_o
);
	// a strong driver wins; a weak or absent high loses to an outside low
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			level_o[k] = pins_i.oe[k] ? pins_i.o[k] : !ext_low_i[k];
		end
	end
endmodule // ubr_pin_env

// ==== tb/ubr_register_bank_bench.sv ====
// bench: register map, divisor, pin drive, result and time-out scenarios
`timescale 1ns/10ps
module ubr_register_bank_bench;
	logic clk_i = 0;
	logic rst_n_i = 0;
	logic ce_i = 1;
	ubr_pkg::ubr_req_t req_i = '0;
	ubr_pkg::ubr_frame_t frame_i = '0;
	logic bus_transition_i = 0;
	logic scl_low_i = 0;
	logic [7:0] ext_low = 8'h00;
	logic [7:0] pin_i, rdata_o, own_address_o;
	logic rvalid_o, bus_reset_o;
	logic [15:0] baud_divisor_o;
	logic [16:0] baud_period_o;
	ubr_pkg::ubr_bus_cfg_t bus_cfg_o;
	ubr_pkg::ubr_pins_t pins_o;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	// short time-out unit keeps the run brief
	ubr_register_bank #(.TIMEOUT_UNIT(4)) ubr_register_bank_i (.clk_i, .rst_n_i, .ce_i, .req_i,
		.rdata_o, .rvalid_o, .baud_divisor_o, .baud_period_o, .frame_i, .bus_transition_i,
		.scl_low_i, .bus_cfg_o, .bus_reset_o, .own_address_o, .pin_i, .pins_o);
	ubr_pin_env ubr_pin_env_i (.pins_i(pins_o), .ext_low_i(ext_low), .level_o(pin_i));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic wrap_up();
		if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req_i = '{1'b1, 1'b0, a, d};
		@(negedge clk_i);
		req_i = '0;
		@(negedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		req_i = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk_i);
		req_i = '0;
		chk({15'h0000, rvalid_o, rdata_o}, {15'h0000, 1'b1, exp});
		@(negedge clk_i);
	endtask
	task automatic t_reset();
		logic [7:0] rv [11] = '{8'hF0, 8'h02, 8'h55, 8'h55, 8'h00, 8'h00, 8'h26, 8'h13,
			8'h13, 8'h66, 8'hF0};
		for (int a = 0; a < 11; a++) begin
			if (a != 4) rd(8'(a), rv[a]);
		end
		chk(24'(baud_period_o), 24'h000300);
	endtask
	task automatic t_baud();
		wr(8'h00, 8'h00);
		chk(24'(baud_divisor_o), 24'h0002F0);
		wr(8'h01, 8'h01);
		chk(24'(baud_divisor_o), 24'h000100);
		chk(24'(baud_period_o), 24'h000110);
	endtask
	task automatic t_regs();
		wr(8'h06, 8'hA4);
		rd(8'h06, 8'hA4);
		wr(8'h08, 8'h07);
		wr(8'h07, 8'h03);
		chk({bus_cfg_o.scl_high, bus_cfg_o.scl_low, 7'h00, bus_cfg_o.scl_sum_ok}, 24'h070301);
		wr(8'h07, 8'h02);
		chk({bus_cfg_o.scl_high, bus_cfg_o.scl_low, 7'h00, bus_cfg_o.scl_sum_ok}, 24'h070200);
		wr(8'h05, 8'h5A);
		rd(8'h05, 8'h00);
		wr(8'h0A, 8'h00);
		rd(8'h0A, 8'hF0);
		wr(8'h0B, 8'h11);
		rd(8'h0B, 8'h00);
		rd(8'h06, 8'hA4);
		// a write offered while the enable is low must be lost
		ce_i = 0;
		wr(8'h06, 8'h5A);
		ce_i = 1;
		rd(8'h06, 8'hA4);
	endtask
	task automatic t_pins();
		wr(8'h02, 8'hE4);
		wr(8'h03, 8'hE4);
		wr(8'h04, 8'h00);
		chk(pins_o, 24'hDD0000);
		repeat (8) @(negedge clk_i);
		rd(8'h04, 8'h22);
		wr(8'h04, 8'hFF);
		chk(pins_o, 24'h444411);
		ext_low = 8'h03;
		@(negedge clk_i);
		ext_low = 8'h01;
		repeat (8) @(negedge clk_i);
		rd(8'h04, 8'hFE);
		ext_low = 8'h03;
		repeat (8) @(negedge clk_i);
		rd(8'h04, 8'hFC);
		ext_low = 8'h00;
	endtask
	task automatic t_result();
		logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h2, 4'h8};
		foreach (codes[k]) begin
			frame_i = '{1'b1, codes[k]};
			@(negedge clk_i);
			frame_i = '0;
			rd(8'h0A, {4'hF, codes[k]});
		end
	endtask
	task automatic t_timeout();
		int n;
		wr(8'h09, 8'h05);
		scl_low_i = 1;
		n = 0;
		while (bus_reset_o !== 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		chk(24'(n >= 7 && n <= 10), 24'h000001);
		scl_low_i = 0;
		repeat (3) @(negedge clk_i);
		scl_low_i = 1;
		n = 0;
		// transitions every four cycles keep reloading an eight-cycle limit
		repeat (10) begin
			bus_transition_i = 1;
			@(negedge clk_i);
			bus_transition_i = 0;
			repeat (3) begin
				@(negedge clk_i);
				n += int'(bus_reset_o !== 1'b0);
			end
		end
		chk(24'(n), 24'h000000);
		wr(8'h09, 8'h04);
		n = 0;
		repeat (30) begin
			@(negedge clk_i);
			n += int'(bus_reset_o !== 1'b0);
		end
		chk(24'(n), 24'h000000);
		scl_low_i = 0;
	endtask
	initial begin
		repeat (12) @(negedge clk_i);
		rst_n_i = 1;
		t_reset();
		t_baud();
		t_regs();
		t_pins();
		t_result();
		t_timeout();
		wrap_up();
	end
endmodule // ubr_register_bank_bench

// ==== tb/ubr_register_bank_chk.sv ====
// checker: port-level properties of the register bank
`timescale 1ns/10ps
module ubr_register_bank_chk #(
	parameter int PINS = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire ubr_pkg::ubr_req_t req_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic [15:0] baud_divisor_o,
	input wire logic [16:0] baud_period_o,
	input wire logic scl_low_i,
	input wire ubr_pkg::ubr_bus_cfg_t bus_cfg_o,
	input wire logic bus_reset_o,
	input wire logic [7:0] own_address_o,
	input wire ubr_pkg::ubr_pins_t pins_o
);
	logic rd_go;
	logic wr_go;
	assign rd_go = ce_i && req_i.rd;
	assign wr_go = ce_i && req_i.wr;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	read_answer_a: assert property (rd_go |=> rvalid_o)
		else $error("read not answered");
	rsvd_zero_a: assert property (rd_go && req_i.addr == 8'h05 |=> rdata_o == 8'h00)
		else $error("reserved slot not zero");
	result_top_a: assert property (rd_go && req_i.addr == 8'h0A |=> rdata_o[7:4] == 4'hF)
		else $error("result upper nibble wrong");
	baud_sum_a: assert property (baud_period_o == {1'b0, baud_divisor_o} + 17'h00010)
		else $error("bit period wrong");
	baud_hold_a: assert property (!$stable(baud_divisor_o) |->
		!$past(rst_n_i) || $past(wr_go && req_i.addr == 8'h01))
		else $error("divisor moved without high byte");
	drive_mix_a: assert property ((pins_o.oe & pins_o.weak_up) == 8'h00 &&
		(pins_o.o & ~pins_o.oe) == 8'h00)
		else $error("pin drive mix illegal");
	reset_float_a: assert property ($rose(rst_n_i) |->
		pins_o.oe == 8'h00 && pins_o.weak_up == 8'h00)
		else $error("pins driven after reset");
	own_addr_a: assert property (wr_go && req_i.addr == 8'h06 |=>
		own_address_o == $past(req_i.wdata))
		else $error("own address not stored");
	tmo_cfg_a: assert property (wr_go && req_i.addr == 8'h09 |=>
		{bus_cfg_o.timeout_val, bus_cfg_o.timeout_en} == $past(req_i.wdata))
		else $error("time-out fields wrong");
	bus_rst_a: assert property (bus_reset_o |-> $past(bus_cfg_o.timeout_en && scl_low_i))
		else $error("bus reset without cause");
endmodule // ubr_register_bank_chk

bind ubr_register_bank ubr_register_bank_chk #(.PINS(PINS)) chk_i (.clk_i, .rst_n_i, .ce_i,
	.req_i, .rdata_o, .rvalid_o, .baud_divisor_o, .baud_period_o, .scl_low_i, .bus_cfg_o,
	.bus_reset_o, .own_address_o, .pins_o);
